// file: design/tss_status.sv
// Tape status and sense reporting register bank with AHB-Lite slave
// How it works
// RULE_01: Adapter word bits 0-7 carry error, subcommand, parity ... overrun.
// RULE_02: Adapter word bits 8-15 carry normal end through interruption.
// RULE_03: Unit status bits: ready, busy, wren, start, end, done, low, pos.
// RULE_04: Program set byte bits 0-2 and 4 are written by host software.
// RULE_05: Host software sets program bits 3,5,6,7 for timeouts and alerts.
// RULE_06: Ready only with tape loaded and tension established.
// RULE_07: Busy sets on disconnected command, holds until done or clear.
// RULE_08: Write enable when not protected; write while off raises attention.
// RULE_09: Start marker bit; backward command at start raises attention.
// RULE_10: End bit set on marker forward, cleared on marker reverse.
// RULE_11: Done sets at stop lock, tape mark in space file, panel rewind.
// RULE_12: Low speed bit follows 12.5 ips; positioning bit follows sequence.
// RULE_13: Check end bit on check end or not capable in space file.
// RULE_14: Bus out parity check on even outbound parity during write.
// RULE_15: Tag bus parity check on even tag bus parity.
// RULE_16: Bit 3 internal write failure, bit 4 sequence error.
// RULE_17: Bit 5 on odd parity on command register bus.
// RULE_18: Bit 6 on odd parity on drive control bus.
// RULE_19: Bit 7 on read path failure or missing read-back.
// RULE_20: Every alert-class sense bit raises attention when it sets.
// RULE_21: Machine check and enable bits never raise an interrupt.
// RULE_22: Byte 6 bits set data check; read-back failure sets bit 7.
// RULE_23: Sense bus parity flag propagates to all remaining bytes 8-15.
// RULE_24: Error bits stay latched until error clear.
`timescale 1ns/1ps
`include "tss_defs.svh"
module tss_status (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [15:0] adapter_status_field,
    input wire logic tape_loaded,
    input wire logic tension_ok,
    input wire logic disc_cmd_start,
    input wire logic disc_cmd_space_file,
    input wire logic stop_lock,
    input wire logic tape_mark_seen,
    input wire logic panel_rewind,
    input wire logic file_protect,
    input wire logic write_cmd,
    input wire logic backward_cmd,
    input wire logic tape_start_marker,
    input wire logic tape_end_marker,
    input wire logic moving_forward,
    input wire logic low_speed,
    input wire logic positioning,
    input wire logic check_end,
    input wire logic not_capable_sf,
    input wire logic write_xfer,
    input wire logic [8:0] outbound_bus,
    input wire logic [8:0] tag_bus,
    input wire logic [8:0] cmd_reg_bus,
    input wire logic [8:0] drv_ctrl_bus,
    input wire logic wr_module_fail,
    input wire logic seq_error,
    input wire logic read_path_fail,
    input wire logic readback_missing,
    input wire logic [7:0] data_check_events,
    input wire logic [7:0] other_sense_set [2:15],
    input wire logic sense_read_active,
    input wire logic [3:0] sense_read_index,
    input wire logic [8:0] sense_bus,
    output logic attention
);
    import tss_pkg::*;

    tss_byte_t unit_status_field;
    logic st_ready;
    logic st_busy;
    logic st_wren;
    logic st_start;
    logic st_end;
    logic st_done;
    logic st_low;
    logic st_pos;
    tss_byte_t program_flags_field;
    tss_byte_t sense [0:15];
    logic [15:0] ext_adapter;
    logic clr;
    logic ph_valid;
    logic ph_write;
    logic [11:0] ph_addr;
    logic end_prev;
    logic [7:0] s1_set;
    logic rb_fail_set;
    logic bus_par_err;
    logic att_write;
    logic att_back;
    logic [7:0] s1_alert_new;
    logic dchk_set;

    // Single-cycle slave: never stalls, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Capture address phase of a selected transfer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr <= 12'h000;
        end else if (hready) begin
            ph_valid <= hsel && htrans[1];
            ph_write <= hwrite;
            ph_addr <= haddr;
        end
    end

    // Error clear is a write to control bit 0, one cycle pulse
    assign clr = ph_valid && ph_write && (ph_addr == `TSS_OFF_CTRL) &&
                 hwdata[`TSS_CTRL_CLR];

    // RULE_01 RULE_02 adapter word bit order kept as presented
    // RULE_21 extended bits never drive attention or interrupts
    assign ext_adapter = adapter_status_field;

    // RULE_04 RULE_05 program flags written only by software
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            program_flags_field <= `TSS_RST_BYTE;
        end else if (ph_valid && ph_write &&
                     ph_addr == `TSS_OFF_PROG_SET) begin
            program_flags_field <= hwdata[7:0];
        end
    end

    // RULE_03 RULE_06 RULE_08 RULE_09 RULE_12 level status bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ready <= 1'b0;
            st_wren <= 1'b0;
            st_start <= 1'b0;
            st_low <= 1'b0;
            st_pos <= 1'b0;
        end else begin
            st_ready <= tape_loaded && tension_ok;
            st_wren <= !file_protect;
            st_start <= tape_start_marker;
            st_low <= low_speed;
            st_pos <= positioning;
        end
    end

    // RULE_10 end bit sets on forward marker edge, clears on reverse edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            end_prev <= 1'b0;
            st_end <= 1'b0;
        end else begin
            end_prev <= tape_end_marker;
            if (tape_end_marker && !end_prev) begin
                st_end <= moving_forward;
            end
        end
    end

    // RULE_11 done flag; a set wins over clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_done <= 1'b0;
        end else if ((stop_lock && !disc_cmd_space_file && st_busy) ||
                     (disc_cmd_space_file && tape_mark_seen) ||
                     panel_rewind) begin
            st_done <= 1'b1;
        end else if (clr) begin
            st_done <= 1'b0;
        end
    end

    // RULE_07 busy from command start until done or clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_busy <= 1'b0;
        end else if (disc_cmd_start || panel_rewind) begin
            st_busy <= 1'b1;
        end else if (clr || st_done) begin
            st_busy <= 1'b0;
        end
    end

    // One flop per bit so each bit keeps a single driver
    assign unit_status_field[`TSS_UB_READY] = st_ready;
    assign unit_status_field[`TSS_UB_BUSY] = st_busy;
    assign unit_status_field[`TSS_UB_WREN] = st_wren;
    assign unit_status_field[`TSS_UB_START] = st_start;
    assign unit_status_field[`TSS_UB_END] = st_end;
    assign unit_status_field[`TSS_UB_DONE] = st_done;
    assign unit_status_field[`TSS_UB_LOW] = st_low;
    assign unit_status_field[`TSS_UB_POS] = st_pos;

    // Sense byte 1 set terms
    always_comb begin
        s1_set = 8'h00;
        // RULE_13 check end sense
        s1_set[`TSS_S1_CHKEND] = check_end || not_capable_sf;
        // RULE_14 even parity on outbound bus during write
        s1_set[`TSS_S1_BUSOUT] = write_xfer && !(^outbound_bus);
        // RULE_15 even parity on tag bus
        s1_set[`TSS_S1_TAG] = !(^tag_bus);
        // RULE_16 write module failure and sequence error
        s1_set[`TSS_S1_WRFAIL] = wr_module_fail;
        s1_set[`TSS_S1_SEQ] = seq_error;
        // RULE_17 odd parity on command register bus
        s1_set[`TSS_S1_CMDPAR] = ^cmd_reg_bus;
        // RULE_18 odd parity on drive control bus
        s1_set[`TSS_S1_DRVPAR] = ^drv_ctrl_bus;
        // RULE_19 RULE_22 read failure or uncovered read-back failure
        s1_set[`TSS_S1_RDFAIL] = read_path_fail || readback_missing ||
                                 rb_fail_set;
    end

    // RULE_22 read-back failure counts only while check end is off
    assign rb_fail_set = data_check_events[`TSS_S6_RBFAIL] &&
                         !sense[1][`TSS_S1_CHKEND];
    assign dchk_set = |(data_check_events &
                        ~(8'h01 << `TSS_S6_RBFAIL));

    // RULE_23 sense bus parity during sense readout of bytes 8-15
    assign bus_par_err = sense_read_active && sense_read_index[3] &&
                         !(^sense_bus);

    // RULE_24 sticky sense bytes 1-15, byte 0 follows unit status; set wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < `TSS_SENSE_BYTES; i++) begin
                sense[i] <= `TSS_RST_BYTE;
            end
        end else begin
            sense[0] <= unit_status_field;
            sense[1] <= (clr ? 8'h00 : sense[1]) | s1_set;
            for (int i = 2; i < `TSS_SENSE_BYTES; i++) begin
                sense[i] <= (clr ? 8'h00 : sense[i]) | other_sense_set[i];
            end
            // RULE_22 byte 6 events and data check
            sense[6] <= (clr ? 8'h00 : sense[6]) | other_sense_set[6] |
                        data_check_events;
            sense[2][`TSS_S2_DCHK] <= (!clr && sense[2][`TSS_S2_DCHK]) ||
                                      other_sense_set[2][`TSS_S2_DCHK] ||
                                      dchk_set;
            // RULE_23 flag stays in every remaining byte
            if (bus_par_err) begin
                for (int i = 8; i < `TSS_SENSE_BYTES; i++) begin
                    if (4'(i) >= sense_read_index) begin
                        sense[i][`TSS_SB_PAR] <= 1'b1;
                    end
                end
            end
        end
    end

    // RULE_08 RULE_09 command-driven attention causes
    assign att_write = write_cmd && !unit_status_field[`TSS_UB_WREN];
    assign att_back = backward_cmd && unit_status_field[`TSS_UB_START];
    // Alert-class byte 1 bits: 1..6 plus uncovered read-back failure
    assign s1_alert_new = s1_set & ~sense[1] & 8'h7E;

    // RULE_20 attention pulse whenever an alert bit newly sets
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            attention <= 1'b0;
        end else begin
            attention <= att_write || att_back || (|s1_alert_new) ||
                         rb_fail_set || bus_par_err;
        end
    end

    // Read mux; unmapped addresses read zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hsel && htrans[1] && !hwrite && hready) begin
            hrdata <= 32'h0000_0000;
            if (haddr == `TSS_OFF_ADPT_WORD) begin
                hrdata <= {16'h0000, ext_adapter};
            end else if (haddr == `TSS_OFF_UNIT_STAT) begin
                hrdata <= {24'h000000, unit_status_field};
            end else if (haddr == `TSS_OFF_PROG_SET) begin
                hrdata <= {24'h000000, program_flags_field};
            end else if (haddr[11:6] == 6'h01 && haddr[1:0] == 2'b00) begin
                hrdata <= {24'h000000, sense[haddr[5:2]]};
            end
        end
    end

    // Cover and check main scenarios
    property p_ready;
        @(posedge hclk) disable iff (!hresetn)
        (tape_loaded && tension_ok) |=> unit_status_field[`TSS_UB_READY];
    endproperty
    a_ready: assert property (p_ready) else $error("ready missing"); // RULE_06
    property p_busy;
        @(posedge hclk) disable iff (!hresetn)
        disc_cmd_start |=> unit_status_field[`TSS_UB_BUSY];
    endproperty
    a_busy: assert property (p_busy) else $error("busy missing"); // RULE_07
    property p_wratt;
        @(posedge hclk) disable iff (!hresetn)
        att_write |=> attention;
    endproperty
    a_wratt: assert property (p_wratt) else $error("no attention"); // RULE_08
    property p_back;
        @(posedge hclk) disable iff (!hresetn)
        (backward_cmd && unit_status_field[`TSS_UB_START]) |=> attention;
    endproperty
    a_back: assert property (p_back) else $error("no attention"); // RULE_09
    property p_done;
        @(posedge hclk) disable iff (!hresetn)
        panel_rewind |=> unit_status_field[`TSS_UB_DONE];
    endproperty
    a_done: assert property (p_done) else $error("done missing"); // RULE_11
    property p_tag;
        @(posedge hclk) disable iff (!hresetn)
        !(^tag_bus) |=> sense[1][`TSS_S1_TAG];
    endproperty
    a_tag: assert property (p_tag) else $error("tag parity lost"); // RULE_15
    property p_cmdpar;
        @(posedge hclk) disable iff (!hresetn)
        (^cmd_reg_bus) |=> sense[1][`TSS_S1_CMDPAR] ##1
            (sense[1][`TSS_S1_CMDPAR] || $past(clr));
    endproperty
    a_cmdpar: assert property (p_cmdpar) else $error("cmd par"); // RULE_17
    property p_dchk;
        @(posedge hclk) disable iff (!hresetn)
        dchk_set |=> sense[2][`TSS_S2_DCHK];
    endproperty
    a_dchk: assert property (p_dchk) else $error("data check"); // RULE_22
    property p_latch;
        @(posedge hclk) disable iff (!hresetn)
        (sense[1][`TSS_S1_SEQ] && !clr) |=> sense[1][`TSS_S1_SEQ];
    endproperty
    a_latch: assert property (p_latch) else $error("unlatched"); // RULE_24
    // Further checks on status flags and sense bits
    property p_nrdy;
        @(posedge hclk) disable iff (!hresetn)
        !(tape_loaded && tension_ok) |=> !unit_status_field[`TSS_UB_READY];
    endproperty
    a_nrdy: assert property (p_nrdy) else $error("bad ready"); // RULE_06
    property p_endf;
        @(posedge hclk) disable iff (!hresetn)
        (tape_end_marker && !$past(tape_end_marker) && moving_forward) |=>
            unit_status_field[`TSS_UB_END];
    endproperty
    a_endf: assert property (p_endf) else $error("end not set"); // RULE_10
    property p_endr;
        @(posedge hclk) disable iff (!hresetn)
        (tape_end_marker && !$past(tape_end_marker) && !moving_forward) |=>
            !unit_status_field[`TSS_UB_END];
    endproperty
    a_endr: assert property (p_endr) else $error("end not clr"); // RULE_10
    property p_sfst;
        @(posedge hclk) disable iff (!hresetn)
        (stop_lock && disc_cmd_space_file && !tape_mark_seen &&
         !panel_rewind && !unit_status_field[`TSS_UB_DONE]) |=>
            !unit_status_field[`TSS_UB_DONE];
    endproperty
    a_sfst: assert property (p_sfst) else $error("early done"); // RULE_11
    property p_chke;
        @(posedge hclk) disable iff (!hresetn)
        (check_end || not_capable_sf) |=> sense[1][`TSS_S1_CHKEND];
    endproperty
    a_chke: assert property (p_chke) else $error("check end"); // RULE_13
    property p_bout;
        @(posedge hclk) disable iff (!hresetn)
        (write_xfer && !(^outbound_bus)) |=> sense[1][`TSS_S1_BUSOUT];
    endproperty
    a_bout: assert property (p_bout) else $error("bus out par"); // RULE_14
    property p_rdf;
        @(posedge hclk) disable iff (!hresetn)
        read_path_fail |=> sense[1][`TSS_S1_RDFAIL];
    endproperty
    a_rdf: assert property (p_rdf) else $error("read fail"); // RULE_19
    property p_spar;
        @(posedge hclk) disable iff (!hresetn)
        (sense_read_active && sense_read_index[3] && !(^sense_bus)) |=>
            sense[15][`TSS_SB_PAR];
    endproperty
    a_spar: assert property (p_spar) else $error("sense par"); // RULE_23
    c_clear: cover property (@(posedge hclk) clr);
    c_rew: cover property (@(posedge hclk) panel_rewind);
    c_att: cover property (@(posedge hclk) attention);
    c_par: cover property (@(posedge hclk) bus_par_err);
endmodule

// file: design/tss_defs.svh
// Offsets, field positions and reset values for the tape status block
`ifndef TSS_DEFS_SVH
`define TSS_DEFS_SVH
`define TSS_OFF_ADPT_WORD 12'h000
`define TSS_OFF_UNIT_STAT 12'h004
`define TSS_OFF_PROG_SET 12'h008
`define TSS_OFF_SENSE_BASE 12'h040
`define TSS_OFF_CTRL 12'h080
`define TSS_SENSE_BYTES 16
`define TSS_RST_BYTE 8'h00
`define TSS_RST_WORD 16'h0000
// Unit status bit positions
`define TSS_UB_READY 0
`define TSS_UB_BUSY 1
`define TSS_UB_WREN 2
`define TSS_UB_START 3
`define TSS_UB_END 4
`define TSS_UB_DONE 5
`define TSS_UB_LOW 6
`define TSS_UB_POS 7
// Interface check byte positions, then data check, read-back failure and sense bus parity bits
`define TSS_S1_CHKEND 0
`define TSS_S1_BUSOUT 1
`define TSS_S1_TAG 2
`define TSS_S1_WRFAIL 3
`define TSS_S1_SEQ 4
`define TSS_S1_CMDPAR 5
`define TSS_S1_DRVPAR 6
`define TSS_S1_RDFAIL 7
`define TSS_S2_DCHK 1
`define TSS_S6_RBFAIL 5
`define TSS_SB_PAR 6
// Control register: bit 0 error clear
`define TSS_CTRL_CLR 0
`endif

// file: design/tss_pkg.sv
// Types for the tape status block
package tss_pkg;
    typedef logic [7:0] tss_byte_t;
    typedef logic [15:0] tss_word_t;
    typedef enum logic [1:0] {
        TSS_ADDR = 2'b01,
        TSS_DATA = 2'b10
    } tss_bus_e;
endpackage

// file: verif/tss_host.sv
// Host adapter model: AHB-Lite master that reads status after operations
`timescale 1ns/1ps
module tss_host (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [11:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic hang
);
    // Idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 12'hFFF;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        hang = 1'b0;
    end
    // Bounded wait for ready, a stuck slave raises hang
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 100) begin
            n++;
            @(posedge hclk);
        end
        if (n >= 100) hang <= 1'b1;
    endtask
    // One whole-word transfer, each phase held until ready
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        haddr <= ~a; // Released lines never keep the old value
        htrans <= 2'b00;
        hwdata <= wr ? wd : ~wd;
        wait_rdy();
        rd = hrdata;
    endtask
endmodule

// file: verif/tape_sense_status_bytes_bench.sv
// Bench for the tape status bank: stimulus, model and comparisons
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tape_sense_status_bytes_bench;
    import tss_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hresp, hang, attention;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd, r;
    logic [15:0] adapter_status_field;
    logic tape_loaded, tension_ok, disc_cmd_start, disc_cmd_space_file;
    logic stop_lock, tape_mark_seen, panel_rewind, file_protect, write_cmd;
    logic backward_cmd, tape_start_marker, tape_end_marker, moving_forward;
    logic low_speed, positioning, check_end, not_capable_sf, write_xfer;
    logic [8:0] outbound_bus, tag_bus, cmd_reg_bus, drv_ctrl_bus, sense_bus;
    logic wr_module_fail, seq_error, read_path_fail, readback_missing;
    logic [7:0] data_check_events;
    logic [7:0] other_sense_set [2:15];
    logic sense_read_active;
    logic [3:0] sense_read_index;
    tss_byte_t e;
    int n_errors = 0, tests_run = 0, att_n = 0, a0, seed, i, k;
    logic e_busy = 1'b0, e_done = 1'b0, e_end = 1'b0;

    tss_status u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp,
        .adapter_status_field, .tape_loaded, .tension_ok, .disc_cmd_start,
        .disc_cmd_space_file, .stop_lock, .tape_mark_seen, .panel_rewind,
        .file_protect, .write_cmd, .backward_cmd, .tape_start_marker,
        .tape_end_marker, .moving_forward, .low_speed, .positioning,
        .check_end, .not_capable_sf, .write_xfer, .outbound_bus, .tag_bus,
        .cmd_reg_bus, .drv_ctrl_bus, .wr_module_fail, .seq_error,
        .read_path_fail, .readback_missing, .data_check_events,
        .other_sense_set, .sense_read_active, .sense_read_index, .sense_bus,
        .attention);
    tss_host u_host (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hang);

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Attention is a one-cycle pulse, so count every high cycle
    always @(posedge hclk) if (attention === 1'b1) att_n++;
    always @(posedge hclk) if (hang === 1'b1) begin
        n_errors++;
        give_verdict();
    end

    task automatic give_verdict();
        $display("errors %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Unit status as the drive should report it
    function automatic tss_byte_t unit_exp();
        return {positioning, low_speed, e_done, e_end, tape_start_marker,
                ~file_protect, e_busy, tape_loaded & tension_ok};
    endfunction
    task automatic rb(input logic [11:0] a, input tss_byte_t x);
        u_host.xfer(1'b0, a, 32'h0, rd);
        `CHK(rd, {24'h000000, x})
    endtask
    task automatic clr();
        u_host.xfer(1'b1, 12'h080, 32'h00000001, rd);
        repeat (2) @(posedge hclk);
    endtask
    // Inject one interface fault cause; parity idles at the good value
    task automatic fault(input int n, input logic on);
        case (n)
            0: outbound_bus <= on ? 9'h003 : 9'h001;
            1: tag_bus <= on ? 9'h003 : 9'h001;
            2: wr_module_fail <= on;
            3: seq_error <= on;
            4: cmd_reg_bus <= on ? 9'h001 : 9'h000;
            5: drv_ctrl_bus <= on ? 9'h001 : 9'h000;
            6: check_end <= on;
            default: read_path_fail <= on;
        endcase
    endtask

    initial begin
        seed = 32'h4630;
        hresetn = 1'b0;
        {tape_loaded, tension_ok, disc_cmd_start, disc_cmd_space_file} = 0;
        {stop_lock, tape_mark_seen, panel_rewind, write_cmd} = 0;
        {backward_cmd, tape_start_marker, tape_end_marker} = 0;
        {moving_forward, low_speed, positioning, check_end} = 0;
        {not_capable_sf, write_xfer, wr_module_fail, seq_error} = 0;
        {read_path_fail, readback_missing, sense_read_active} = 0;
        file_protect = 1'b1;
        adapter_status_field = 16'h0000;
        {outbound_bus, tag_bus} = {9'h001, 9'h001};
        {cmd_reg_bus, drv_ctrl_bus, sense_bus} = 0;
        data_check_events = 8'h00;
        sense_read_index = 4'h0;
        for (i = 2; i < 16; i++) other_sense_set[i] = 8'h00;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rb(12'h004, 8'h00);
        rb(12'h044, 8'h00);
        r = $random(seed);
        adapter_status_field <= r[15:0];
        repeat (2) @(posedge hclk);
        u_host.xfer(1'b0, 12'h000, 32'h0, rd);
        `CHK(rd, {16'h0000, r[15:0]})
        u_host.xfer(1'b1, 12'h008, r, rd);
        rb(12'h008, r[7:0]);
        rb(12'h0FC, 8'h00);
        `CHK(hresp, 1'b0)
        for (i = 0; i < 8; i++) begin
            r = $random(seed);
            {tape_loaded, tension_ok, file_protect, tape_start_marker,
             low_speed, positioning} <= r[5:0];
            repeat (3) @(posedge hclk);
            rb(12'h004, unit_exp());
            rb(12'h040, unit_exp());
        end
        {file_protect, tape_start_marker} <= 2'b11;
        // Let the status flops settle before the commands
        repeat (2) @(posedge hclk);
        a0 = att_n;
        write_cmd <= 1'b1;
        @(posedge hclk) write_cmd <= 1'b0;
        backward_cmd <= 1'b1;
        @(posedge hclk) backward_cmd <= 1'b0;
        repeat (3) @(posedge hclk);
        `CHK(att_n, a0 + 2)
        for (i = 0; i < 2; i++) begin
            moving_forward <= ~i[0];
            tape_end_marker <= 1'b1;
            @(posedge hclk) tape_end_marker <= 1'b0;
            e_end = ~i[0];
            repeat (3) @(posedge hclk);
            rb(12'h004, unit_exp());
        end
        disc_cmd_start <= 1'b1;
        @(posedge hclk) disc_cmd_start <= 1'b0;
        e_busy = 1'b1;
        repeat (3) @(posedge hclk);
        rb(12'h004, unit_exp());
        stop_lock <= 1'b1;
        @(posedge hclk) stop_lock <= 1'b0;
        {e_busy, e_done} = 2'b01;
        repeat (3) @(posedge hclk);
        rb(12'h004, unit_exp());
        clr();
        e_done = 1'b0;
        rb(12'h004, unit_exp());
        // Space file: stop lock alone must not end it, a tape mark does
        disc_cmd_space_file <= 1'b1;
        disc_cmd_start <= 1'b1;
        @(posedge hclk) disc_cmd_start <= 1'b0;
        stop_lock <= 1'b1;
        @(posedge hclk) stop_lock <= 1'b0;
        e_busy = 1'b1;
        repeat (3) @(posedge hclk);
        rb(12'h004, unit_exp());
        tape_mark_seen <= 1'b1;
        @(posedge hclk) tape_mark_seen <= 1'b0;
        {e_busy, e_done} = 2'b01;
        repeat (3) @(posedge hclk);
        rb(12'h004, unit_exp());
        disc_cmd_space_file <= 1'b0;
        clr();
        // Panel load-rewind completes the operation
        panel_rewind <= 1'b1;
        @(posedge hclk) panel_rewind <= 1'b0;
        repeat (3) @(posedge hclk);
        rb(12'h004, unit_exp());
        clr();
        e_done = 1'b0;
        write_xfer <= 1'b1;
        // Each cause alone, then latched read, then clear
        for (k = 0; k < 8; k++) begin
            a0 = att_n;
            fault(k, 1'b1);
            @(posedge hclk) fault(k, 1'b0);
            repeat (3) @(posedge hclk);
            e = 8'h01 << ((k < 6) ? k + 1 : (k == 6) ? 0 : 7);
            rb(12'h044, e);
            `CHK(att_n, a0 + ((k < 6) ? 1 : 0))
            clr();
            rb(12'h044, 8'h00);
        end
        a0 = att_n;
        data_check_events <= 8'h24;
        @(posedge hclk) data_check_events <= 8'h00;
        repeat (3) @(posedge hclk);
        rb(12'h058, 8'h24);
        rb(12'h044, 8'h80);
        u_host.xfer(1'b0, 12'h048, 32'h0, rd);
        `CHK(rd[1], 1'b1)
        `CHK(att_n, a0 + 1)
        // Sense bus parity error at a random readout index 8..15
        a0 = att_n;
        r = $random(seed);
        sense_read_active <= 1'b1;
        sense_read_index <= {1'b1, r[2:0]};
        sense_bus <= 9'h000;
        @(posedge hclk) sense_read_active <= 1'b0;
        sense_bus <= 9'h001;
        repeat (3) @(posedge hclk);
        for (i = 8; i < 16; i++) begin
            e = (i >= 8 + r[2:0]) ? 8'h40 : 8'h00;
            rb(12'(64 + 4 * i), e);
        end
        `CHK(att_n, a0 + 1)
        clr();
        rb(12'h07C, 8'h00);
        give_verdict();
    end
endmodule
